// ==== pkg/mac_pause_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the pause and tag block
`ifndef MAC_PAUSE_CFG_SVH
`define MAC_PAUSE_CFG_SVH

`define ADDR_W              8
`define OFF_PAUSE_FLOW_CTL  8'h08
`define OFF_FIRST_TAG_ID    8'h09
`define OFF_SECOND_TAG_ID   8'h0a
`define OFF_MAC_MODE        8'h10

`define FLOW_PAUSE_MSB      31
`define FLOW_PAUSE_LSB      16
`define FLOW_CTL_FLAG_BIT   2
`define FLOW_ENABLE_BIT     1
`define FLOW_BUSY_BIT       0
`define TAG_ID_MSB          15
`define MODE_FULL_DUPLEX    0
`define MODE_TX_ENABLE      1
`define MODE_PROMISC        2
`define MODE_SPEED_100      3

`define FLOW_RESET          16'h0000
`define TAG_ID_RESET        16'h0000
`define MODE_RESET          4'h0

`define PAUSE_DA            48'h0180c2000001
`define PAUSE_ETHERTYPE     16'h8808
`define PAUSE_OPCODE        16'h0001
`define HDR_BYTES           18
`define MAX_LEN_PLAIN       16'd1518
`define MAX_LEN_TAGGED      16'd1522

`define CLK_PERIOD_NS       8
`define SLOT_TIME_100_NS    5120
`define SLOT_TIME_10_NS     51200
`define SLOT_CYC_100        (`SLOT_TIME_100_NS / `CLK_PERIOD_NS)
`define SLOT_CYC_10         (`SLOT_TIME_10_NS / `CLK_PERIOD_NS)

`endif

// ==== pkg/mac_pause_pkg.sv ====
// Types shared by the pause and tag block and its users
package mac_pause_pkg;

  typedef struct packed {
    logic       valid;
    logic       sof;
    logic       eof;
    logic       err;
    logic [7:0] data;
  } rx_byte_t;

  typedef struct packed {
    logic        valid;
    logic        filter;
    logic        pause;
    logic        first_tag;
    logic        second_tag;
    logic        too_long;
    logic        err;
    logic [15:0] length;
  } rx_status_t;

  typedef struct packed {
    logic speed_100;
    logic promisc;
    logic tx_enable;
    logic full_duplex;
  } mode_t;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_PAUSE_SEND,
    TX_BACKPRESSURE
  } tx_state_t;

endpackage : mac_pause_pkg

// ==== logic/mac_pause_flow_and_tag_detect.sv ====
// Flow control (pause send/receive, backpressure) and tag detection of the MAC
//
// Behaviour
// R1: sent pause frames carry programmed pause time
// R2: software programs pause time before enabling
// R3: flagging set: pause frame sets filter flag
// R4: flagging clear: pause frame filter flag cleared
// R5: act on pause only full duplex, enabled
// R6: forward every received frame's data
// R7: application keeps or drops by status
// R8: filtering mode overrides control frame flagging
// R9: enabled: decode pause, hold transmitter quanta
// R10: disabled: no decode, no transmitter hold
// R11: half duplex: enable means backpressure instead
// R12: busy high during pause or backpressure
// R13: software waits idle busy, writes zero
// R14: first tag id compared to bytes 13-14
// R15: second tag id compared to bytes 13-14
// R16: tagged frame max length 1522, else 1518
// R17: software programs tag ids to 8100h
// R18: tag registers reset to zero
// R19: no pause or backpressure when transmitter off (a pause send already under way still runs until i_pause_done)
// R20: slot is 512 bit times, reloading counter
`timescale 1ns/100ps
`include "mac_pause_cfg.svh"

module mac_pause_flow_and_tag_detect #(
  parameter int SLOT_CYC_10 = `SLOT_CYC_10
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_reset,
  input  wire logic [`ADDR_W-1:0]      i_addr,
  input  wire logic [31:0]             i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output logic      [31:0]             o_rdata,
  input  wire mac_pause_pkg::rx_byte_t i_rx,
  input  wire logic                    i_addr_match,
  output mac_pause_pkg::rx_byte_t      o_rx,
  output mac_pause_pkg::rx_status_t    o_rx_status,
  input  wire logic                    i_flow_req,
  input  wire logic                    i_pause_done,
  output logic                         o_pause_send,
  output logic      [15:0]             o_pause_time,
  output logic                         o_backpressure,
  output logic                         o_tx_hold
);

  localparam logic [12:0] SLOT_100 = 13'(`SLOT_CYC_100);
  localparam logic [12:0] SLOT_10  = 13'(SLOT_CYC_10);
  localparam logic [4:0]  HDR_N    = 5'(`HDR_BYTES);

  // Register and transmit side state
  logic [15:0]                pause_time_value_q, pause_time_value_d;
  logic                       control_frame_flagging_q, control_frame_flagging_d;
  logic                       flow_ctl_enable_q, flow_ctl_enable_d;
  logic [15:0]                first_tag_id_q, first_tag_id_d;
  logic [15:0]                second_tag_id_q, second_tag_id_d;
  mac_pause_pkg::mode_t       mode_q, mode_d;
  logic [31:0]                rdata_q, rdata_d;
  mac_pause_pkg::tx_state_t   tx_state_q, tx_state_d;
  logic [15:0]                tx_time_q, tx_time_d;
  logic [15:0]                quanta_q, quanta_d;
  logic [12:0]                slot_q, slot_d;
  logic                       flow_ctl_busy;
  logic                       flow_ctl_on;

  // Receive side state
  logic [7:0]                 hdr_q [`HDR_BYTES];
  logic [7:0]                 hdr_d [`HDR_BYTES];
  logic [15:0]                cnt_q, cnt_d;
  mac_pause_pkg::rx_byte_t    rx_q, rx_d;
  mac_pause_pkg::rx_status_t  st_q, st_d;
  logic                       pause_load;
  logic [15:0]                pause_rx_time;

  assign flow_ctl_busy = (tx_state_q != mac_pause_pkg::TX_IDLE);
  // Pause reception only applies with flow control on in full duplex
  assign flow_ctl_on   = flow_ctl_enable_q & mode_q.full_duplex;  // [R5] [R11]

  always_comb begin
    pause_time_value_d       = pause_time_value_q;
    control_frame_flagging_d = control_frame_flagging_q;
    flow_ctl_enable_d        = flow_ctl_enable_q;
    first_tag_id_d           = first_tag_id_q;
    second_tag_id_d          = second_tag_id_q;
    mode_d                   = mode_q;
    rdata_d                  = 32'h0000_0000;
    if (i_wr) begin
      if (i_addr == `OFF_PAUSE_FLOW_CTL) begin
        // Busy bit is status only; written value is ignored
        pause_time_value_d       = i_wdata[`FLOW_PAUSE_MSB:`FLOW_PAUSE_LSB];
        control_frame_flagging_d = i_wdata[`FLOW_CTL_FLAG_BIT];
        flow_ctl_enable_d        = i_wdata[`FLOW_ENABLE_BIT];
      end else if (i_addr == `OFF_FIRST_TAG_ID) begin
        first_tag_id_d = i_wdata[`TAG_ID_MSB:0];
      end else if (i_addr == `OFF_SECOND_TAG_ID) begin
        second_tag_id_d = i_wdata[`TAG_ID_MSB:0];
      end else if (i_addr == `OFF_MAC_MODE) begin
        mode_d.full_duplex = i_wdata[`MODE_FULL_DUPLEX];
        mode_d.tx_enable   = i_wdata[`MODE_TX_ENABLE];
        mode_d.promisc     = i_wdata[`MODE_PROMISC];
        mode_d.speed_100   = i_wdata[`MODE_SPEED_100];
      end
    end
    if (i_rd) begin
      if (i_addr == `OFF_PAUSE_FLOW_CTL) begin
        rdata_d[`FLOW_PAUSE_MSB:`FLOW_PAUSE_LSB] = pause_time_value_q;
        rdata_d[`FLOW_CTL_FLAG_BIT]              = control_frame_flagging_q;
        rdata_d[`FLOW_ENABLE_BIT]                = flow_ctl_enable_q;
        rdata_d[`FLOW_BUSY_BIT]                  = flow_ctl_busy;
      end else if (i_addr == `OFF_FIRST_TAG_ID) begin
        rdata_d[`TAG_ID_MSB:0] = first_tag_id_q;
      end else if (i_addr == `OFF_SECOND_TAG_ID) begin
        rdata_d[`TAG_ID_MSB:0] = second_tag_id_q;
      end else if (i_addr == `OFF_MAC_MODE) begin
        rdata_d[`MODE_FULL_DUPLEX] = mode_q.full_duplex;
        rdata_d[`MODE_TX_ENABLE]   = mode_q.tx_enable;
        rdata_d[`MODE_PROMISC]     = mode_q.promisc;
        rdata_d[`MODE_SPEED_100]   = mode_q.speed_100;
      end
    end

    // Flow control transmit sequencing
    tx_state_d = tx_state_q;
    tx_time_d  = tx_time_q;
    case (tx_state_q)
      mac_pause_pkg::TX_IDLE: begin
        if (i_flow_req && flow_ctl_enable_q && mode_q.tx_enable) begin  // [R19]
          if (mode_q.full_duplex) begin
            tx_state_d = mac_pause_pkg::TX_PAUSE_SEND;
            tx_time_d  = pause_time_value_q;  // [R1]
          end else begin
            tx_state_d = mac_pause_pkg::TX_BACKPRESSURE;  // [R11]
          end
        end
      end
      mac_pause_pkg::TX_PAUSE_SEND: begin
        if (i_pause_done) begin
          tx_state_d = mac_pause_pkg::TX_IDLE;  // [R12]
        end
      end
      mac_pause_pkg::TX_BACKPRESSURE: begin
        if (!i_flow_req || !flow_ctl_enable_q || !mode_q.tx_enable || mode_q.full_duplex) begin
          tx_state_d = mac_pause_pkg::TX_IDLE;  // [R19]
        end
      end
      default: begin
        tx_state_d = mac_pause_pkg::TX_IDLE;
      end
    endcase

    // Pause timer: quanta count down once per slot time
    quanta_d = quanta_q;
    slot_d   = slot_q;
    if (pause_load) begin
      quanta_d = pause_rx_time;  // [R9] [R20]
      slot_d   = mode_q.speed_100 ? SLOT_100 : SLOT_10;
    end else if (!flow_ctl_on) begin
      quanta_d = 16'h0000;  // [R10]
    end else if (quanta_q != 16'h0000) begin
      if (slot_q <= 13'h0001) begin
        quanta_d = quanta_q - 16'h0001;
        slot_d   = mode_q.speed_100 ? SLOT_100 : SLOT_10;  // [R20]
      end else begin
        slot_d = slot_q - 13'h0001;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pause_time_value_q       <= `FLOW_RESET;
      control_frame_flagging_q <= 1'b0;
      flow_ctl_enable_q        <= 1'b0;
      first_tag_id_q           <= `TAG_ID_RESET;  // [R18]
      second_tag_id_q          <= `TAG_ID_RESET;  // [R18]
      mode_q                   <= `MODE_RESET;
      rdata_q                  <= 32'h0000_0000;
      tx_state_q               <= mac_pause_pkg::TX_IDLE;
      tx_time_q                <= 16'h0000;
      quanta_q                 <= 16'h0000;
      slot_q                   <= 13'h0000;
    end else begin
      pause_time_value_q       <= pause_time_value_d;
      control_frame_flagging_q <= control_frame_flagging_d;
      flow_ctl_enable_q        <= flow_ctl_enable_d;
      first_tag_id_q           <= first_tag_id_d;
      second_tag_id_q          <= second_tag_id_d;
      mode_q                   <= mode_d;
      rdata_q                  <= rdata_d;
      tx_state_q               <= tx_state_d;
      tx_time_q                <= tx_time_d;
      quanta_q                 <= quanta_d;
      slot_q                   <= slot_d;
    end
  end

  assign o_rdata        = rdata_q;
  assign o_pause_send   = (tx_state_q == mac_pause_pkg::TX_PAUSE_SEND);  // [R12]
  assign o_pause_time   = tx_time_q;  // [R1]
  assign o_backpressure = (tx_state_q == mac_pause_pkg::TX_BACKPRESSURE);  // [R12]
  assign o_tx_hold      = (quanta_q != 16'h0000);  // [R9]

  // Receive: header capture, pause decode, tag match, length check
  logic [15:0] len;
  logic [15:0] type_field;
  logic        is_pause;
  logic        tag1_hit;
  logic        tag2_hit;
  logic [47:0] da;

  always_comb begin
    hdr_d = hdr_q;
    cnt_d = cnt_q;
    rx_d  = i_rx;  // [R6]
    st_d  = '0;
    len   = i_rx.sof ? 16'h0001 : cnt_q + 16'h0001;
    if (i_rx.valid) begin
      if (i_rx.sof) begin
        hdr_d[0] = i_rx.data;
      end else if (cnt_q < 16'(HDR_N)) begin
        hdr_d[cnt_q[4:0]] = i_rx.data;
      end
      cnt_d = len;
    end
    // Decode from the next header so the last byte of an 18-byte frame counts
    da         = {hdr_d[0], hdr_d[1], hdr_d[2], hdr_d[3], hdr_d[4], hdr_d[5]};
    type_field = {hdr_d[12], hdr_d[13]};
    tag1_hit   = (type_field == first_tag_id_q);  // [R14]
    tag2_hit   = (type_field == second_tag_id_q);  // [R15]
    // Decode is skipped entirely when flow control is off
    is_pause   = flow_ctl_on && !i_rx.err && (da == `PAUSE_DA)  // [R10]
                 && (type_field == `PAUSE_ETHERTYPE)
                 && ({hdr_d[14], hdr_d[15]} == `PAUSE_OPCODE);
    pause_rx_time = {hdr_d[16], hdr_d[17]};
    pause_load    = i_rx.valid && i_rx.eof && is_pause;  // [R5] [R9]
    if (i_rx.valid && i_rx.eof) begin
      st_d.valid      = 1'b1;
      st_d.err        = i_rx.err;
      st_d.length     = len;
      st_d.pause      = is_pause;
      st_d.first_tag  = tag1_hit;
      st_d.second_tag = tag2_hit;
      st_d.too_long   = len > ((tag1_hit || tag2_hit) ? `MAX_LEN_TAGGED
                                                      : `MAX_LEN_PLAIN);  // [R16]
      if (mode_q.promisc) begin
        st_d.filter = 1'b1;  // [R8]
      end else if (is_pause) begin
        st_d.filter = control_frame_flagging_q;  // [R3] [R4]
      end else begin
        st_d.filter = i_addr_match;  // [R7]
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int i = 0; i < `HDR_BYTES; i++) begin
        hdr_q[i] <= 8'h00;
      end
      cnt_q <= 16'h0000;
      rx_q  <= '0;
      st_q  <= '0;
    end else begin
      hdr_q <= hdr_d;
      cnt_q <= cnt_d;
      rx_q  <= rx_d;
      st_q  <= st_d;
    end
  end

  assign o_rx        = rx_q;  // [R6]
  assign o_rx_status = st_q;

endmodule : mac_pause_flow_and_tag_detect

// ==== bench/mac_pause_assertions.sv ====
// Port-level checks of the pause and tag block
`timescale 1ns/100ps
`include "mac_pause_cfg.svh"
module mac_pause_assertions #(
  parameter int SLOT_CYC_10 = `SLOT_CYC_10
) (
  input wire logic                       i_clk,
  input wire logic                       i_reset,
  input wire logic [`ADDR_W-1:0]         i_addr,
  input wire logic [31:0]                i_wdata,
  input wire logic                       i_wr,
  input wire logic                       i_rd,
  input wire logic [31:0]                o_rdata,
  input wire mac_pause_pkg::rx_byte_t    i_rx,
  input wire logic                       i_addr_match,
  input wire mac_pause_pkg::rx_byte_t    o_rx,
  input wire mac_pause_pkg::rx_status_t  o_rx_status,
  input wire logic                       i_flow_req,
  input wire logic                       i_pause_done,
  input wire logic                       o_pause_send,
  input wire logic [15:0]                o_pause_time,
  input wire logic                       o_backpressure,
  input wire logic                       o_tx_hold
);
  logic [31:0]          flow_q;
  mac_pause_pkg::mode_t md_q;
  // Shadow copies of the flow and mode registers
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      flow_q <= '0;
      md_q <= '0;
    end else if (i_wr && i_addr == `OFF_PAUSE_FLOW_CTL) begin
      flow_q <= i_wdata;
    end else if (i_wr && i_addr == `OFF_MAC_MODE) begin
      md_q <= i_wdata[3:0];
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence s_send_wait;
    o_pause_send && !i_pause_done;
  endsequence
  sequence s_send_ok;
    i_flow_req && flow_q[1] && md_q.tx_enable;
  endsequence
  a_rx_forward: assert property (o_rx == $past(i_rx))
    else $error("received byte not forwarded");
  a_send_time: assert property ($rose(o_pause_send) |-> o_pause_time == flow_q[31:16])
    else $error("pause time differs from register");
  a_send_cause: assert property ($rose(o_pause_send) |-> $past(md_q.full_duplex) ##0
    $past(i_flow_req && flow_q[1] && md_q.tx_enable)) else $error("pause send without cause");
  a_bp_cause: assert property ($rose(o_backpressure) |-> $past(!md_q.full_duplex)
    ##0 $past(i_flow_req && flow_q[1] && md_q.tx_enable)) else $error("backpressure cause");
  a_send_holds: assert property (s_send_wait |=> o_pause_send)
    else $error("pause send dropped early");
  a_filter_flag: assert property (o_rx_status.valid && o_rx_status.pause
    && !$past(md_q.promisc) |-> o_rx_status.filter == $past(flow_q[2]))
    else $error("filter flag wrong");
  a_promisc_flag: assert property (o_rx_status.valid && $past(md_q.promisc)
    |-> o_rx_status.filter) else $error("promiscuous filter flag wrong");
  a_hold_cause: assert property ($rose(o_tx_hold) |-> o_rx_status.valid &&
    o_rx_status.pause && $past(flow_q[1] && md_q.full_duplex)) else $error("hold no cause");
  a_tag_length: assert property (o_rx_status.valid |-> o_rx_status.too_long ==
    (o_rx_status.length > ((o_rx_status.first_tag || o_rx_status.second_tag) ?
    `MAX_LEN_TAGGED : `MAX_LEN_PLAIN))) else $error("length limit wrong");
endmodule : mac_pause_assertions

bind mac_pause_flow_and_tag_detect mac_pause_assertions #(.SLOT_CYC_10(SLOT_CYC_10)) chk (
  .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_rx(i_rx), .i_addr_match(i_addr_match), .o_rx(o_rx),
  .o_rx_status(o_rx_status), .i_flow_req(i_flow_req), .i_pause_done(i_pause_done),
  .o_pause_send(o_pause_send), .o_pause_time(o_pause_time),
  .o_backpressure(o_backpressure), .o_tx_hold(o_tx_hold));

// ==== bench/mac_link_partner.sv ====
// Far side model: sends frames byte by byte and completes pause transmissions
`timescale 1ns/100ps
`include "mac_pause_cfg.svh"
module mac_link_partner (
  input  wire logic                 i_clk,
  input  wire logic                 i_pause_send,
  output mac_pause_pkg::rx_byte_t   o_rx,
  output logic                      o_pause_done
);
  int done_dly = 2;
  int cnt = 0;
  initial begin
    o_rx = '0;
    o_pause_done = 1'b0;
  end
  // Pause frame leaves the wire done_dly + 1 cycles after pause send rises
  always @(posedge i_clk) begin
    cnt <= (i_pause_send && !o_pause_done) ? cnt + 1 : 0;
    o_pause_done <= i_pause_send && !o_pause_done && cnt >= done_dly;
  end
  task automatic send(input int len, input logic [15:0] ety, input logic [15:0] pt);
    logic [143:0] hdr;
    logic [7:0]   b;
    hdr = {`PAUSE_DA, 48'h0, ety, `PAUSE_OPCODE, pt};
    for (int i = 1; i <= len; i++) begin
      b = (i <= 18) ? hdr[8*(18-i) +: 8] : i[7:0];
      @(posedge i_clk);
      o_rx <= '{1'b1, i == 1, i == len, 1'b0, b};
    end
    @(posedge i_clk);
    // Idle line holds the inverted last byte, not the last byte
    o_rx <= '{1'b0, 1'b0, 1'b0, 1'b0, ~o_rx.data};
  endtask : send
endmodule : mac_link_partner

// ==== bench/mac_pause_flow_and_tag_detect_bench.sv ====
// Self-checking bench of the pause and tag block
`timescale 1ns/100ps
`include "mac_pause_cfg.svh"
module mac_pause_flow_and_tag_detect_bench;
  localparam int SLOT = 20;
  logic i_clk = 1'b0, i_reset = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_flow_req = 1'b0;
  logic [`ADDR_W-1:0] i_addr = '0;
  logic addr_match = 1'b0;
  logic [31:0] i_wdata = '0, o_rdata;
  logic [15:0] o_pause_time;
  logic o_pause_send, o_backpressure, o_tx_hold, pause_done;
  mac_pause_pkg::rx_byte_t rx, o_rx;
  mac_pause_pkg::rx_status_t o_rx_status, st;
  int err_total = 0, samples_checked = 0, hold_n = 0;
  always #4 i_clk = ~i_clk;
  mac_pause_flow_and_tag_detect #(.SLOT_CYC_10(SLOT)) DUT (
    .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_rx(rx), .i_addr_match(addr_match), .o_rx(o_rx),
    .o_rx_status(o_rx_status), .i_flow_req(i_flow_req), .i_pause_done(pause_done),
    .o_pause_send(o_pause_send), .o_pause_time(o_pause_time),
    .o_backpressure(o_backpressure), .o_tx_hold(o_tx_hold));
  mac_link_partner link (.i_clk(i_clk), .i_pause_send(o_pause_send), .o_rx(rx),
    .o_pause_done(pause_done));
  always @(posedge i_clk) begin
    if (o_rx_status.valid) st <= o_rx_status;
    hold_n <= hold_n + int'(o_tx_hold);
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chkb(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask : chkb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk(nm, e, o_rdata);
  endtask : rd
  // Sends one frame, then waits out any pause hold it causes with the 10 Mb/s slot of SLOT cycles
  task automatic frame(input int len, input logic [15:0] ety, input logic [15:0] pt);
    @(negedge i_clk);
    hold_n = 0;
    link.send(len, ety, pt);
    repeat (pt * SLOT + 8) @(posedge i_clk);
  endtask : frame
  task automatic t_regs;
    rd(`OFF_FIRST_TAG_ID, 32'h0, "tag1 reset");
    rd(`OFF_SECOND_TAG_ID, 32'h0, "tag2 reset");
    wr(8'h20, 32'hffffffff);
    rd(8'h20, 32'h0, "unmapped");
    wr(`OFF_FIRST_TAG_ID, 32'hffff8100);
    rd(`OFF_FIRST_TAG_ID, 32'h00008100, "tag1");
    wr(`OFF_SECOND_TAG_ID, 32'h00009100);
    rd(`OFF_SECOND_TAG_ID, 32'h00009100, "tag2");
  endtask : t_regs
  task automatic t_tags;
    frame(1522, 16'h8100, 16'h0);
    chkb("tag1 hit", 1'b1, st.first_tag);
    chkb("tagged long", 1'b0, st.too_long);
    chk("length", 32'd1522, {16'h0, st.length});
    chkb("no match", 1'b0, st.filter);
    addr_match <= 1'b1;
    frame(1522, 16'h9100, 16'h0);
    chkb("tag2 hit", 1'b1, st.second_tag);
    chkb("tag1 miss", 1'b0, st.first_tag);
    chkb("addr match", 1'b1, st.filter);
    addr_match <= 1'b0;
    frame(1519, 16'h0800, 16'h0);
    chkb("plain long", 1'b1, st.too_long);
    chkb("match gone", 1'b0, st.filter);
  endtask : t_tags
  task automatic t_pause_rx;
    wr(`OFF_MAC_MODE, 32'h3);
    wr(`OFF_PAUSE_FLOW_CTL, 32'h6);
    frame(64, `PAUSE_ETHERTYPE, 16'h3);
    chkb("flag set", 1'b1, st.filter);
    chkb("hold span", 1'b1, hold_n >= 3 * SLOT - 1 && hold_n <= 3 * SLOT + 1);
    wr(`OFF_PAUSE_FLOW_CTL, 32'h2);
    frame(64, `PAUSE_ETHERTYPE, 16'h3);
    chkb("flag clear", 1'b0, st.filter);
    wr(`OFF_MAC_MODE, 32'h7);
    frame(64, `PAUSE_ETHERTYPE, 16'h3);
    chkb("promisc", 1'b1, st.filter);
    wr(`OFF_PAUSE_FLOW_CTL, 32'h4);
    frame(64, `PAUSE_ETHERTYPE, 16'h3);
    chk("hold off", 32'h0, hold_n);
    wr(`OFF_PAUSE_FLOW_CTL, 32'h2);
    wr(`OFF_MAC_MODE, 32'h2);
    frame(64, `PAUSE_ETHERTYPE, 16'h3);
    chk("hold half", 32'h0, hold_n);
    wr(`OFF_MAC_MODE, 32'hb);
    frame(18, `PAUSE_ETHERTYPE, 16'h1);
    repeat (`SLOT_CYC_100) @(posedge i_clk);
    chkb("short pause", 1'b1, st.pause);
    chkb("hold fast", 1'b1, hold_n >= `SLOT_CYC_100 - 1 && hold_n <= `SLOT_CYC_100 + 1);
  endtask : t_pause_rx
  task automatic t_flow_tx;
    wr(`OFF_MAC_MODE, 32'h3);
    wr(`OFF_PAUSE_FLOW_CTL, 32'h12340000);
    wr(`OFF_PAUSE_FLOW_CTL, 32'h12340002);
    link.done_dly = 20;
    i_flow_req <= 1'b1;
    for (int n = 0; n < 10 && o_pause_send !== 1'b1; n++) @(negedge i_clk);
    chkb("pause send", 1'b1, o_pause_send);
    chk("pause time", 32'h1234, {16'h0, o_pause_time});
    @(posedge i_clk);
    i_flow_req <= 1'b0;
    rd(`OFF_PAUSE_FLOW_CTL, 32'h12340003, "busy set");
    repeat (30) @(posedge i_clk);
    rd(`OFF_PAUSE_FLOW_CTL, 32'h12340002, "busy clear");
    wr(`OFF_MAC_MODE, 32'h2);
    i_flow_req <= 1'b1;
    repeat (3) @(negedge i_clk);
    chkb("backpressure", 1'b1, o_backpressure);
    rd(`OFF_PAUSE_FLOW_CTL, 32'h12340003, "bp busy");
    @(posedge i_clk);
    i_flow_req <= 1'b0;
    wr(`OFF_MAC_MODE, 32'h1);
    i_flow_req <= 1'b1;
    repeat (5) @(negedge i_clk);
    chkb("tx off", 1'b0, o_pause_send);
    wr(`OFF_MAC_MODE, 32'h0);
    repeat (3) @(negedge i_clk);
    chkb("tx off bp", 1'b0, o_backpressure);
    @(posedge i_clk);
    i_flow_req <= 1'b0;
  endtask : t_flow_tx
  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  // Tests need about 6000 cycles; the limit leaves wide margin
  initial begin
    repeat (40000) @(posedge i_clk);
    err_total++;
    results();
  end
  initial begin
    repeat (16) @(posedge i_clk);
    i_reset <= 1'b0;
    t_regs();
    t_tags();
    t_pause_rx();
    t_flow_tx();
    results();
  end
endmodule : mac_pause_flow_and_tag_detect_bench
